/* pkg/gpi_defines.svh */
`ifndef GPI_DEFINES_SVH
`define GPI_DEFINES_SVH
// Summary of operation
// (RULE1) Each enable mask bit passes its pin's interrupt at 1, blocks at 0.
// (RULE2) Clearing an enable bit never touches that pin's pending flag.
// (RULE3) Writing ones to the enable-set alias sets those enable bits only.
// (RULE4) Writing ones to the enable-clear alias clears those enable bits only.
// (RULE5) Pending flags read 1 while pending; read-only, reset to zero.
// (RULE6) Writing 1 to a flag-clear bit resets that pin's pending flag.
// (RULE7) Writing 0 to a flag-clear bit leaves its pending flag alone.
// (RULE8) Software keeps bits of absent pins at their reset values.
// (RULE9) The wakeup-enable slot reads zero; software never modifies it.
// (RULE10) Trigger-type bit picks edge detection at 1, level at 0.
// (RULE11) Polarity picks low/high in level mode, falling/rising in edge mode.
// (RULE12) Dual-edge in edge mode triggers on both edges, ignoring polarity.
// (RULE13) Only pins with input connect set may detect interrupt conditions.
// (RULE14) Port interrupt output is the OR of pending AND enable bits.

// ****************************************************************
// Sizes, offsets and reset values
// ****************************************************************
`define GPI_PINS          32
`define GPI_OFS_MODE      8'h28
`define GPI_OFS_POL       8'h2c
`define GPI_OFS_INCON     8'h30
`define GPI_OFS_EN        8'h34
`define GPI_OFS_EN_SET    8'h38
`define GPI_OFS_EN_CLR    8'h3c
`define GPI_OFS_PEND      8'h40
`define GPI_OFS_FL_CLR    8'h48
`define GPI_OFS_WKEN      8'h4c
`define GPI_OFS_WKEN_SET  8'h50
`define GPI_OFS_WKEN_CLR  8'h54
`define GPI_OFS_DUAL      8'h5c
`define GPI_OFS_EVT_STAT  8'h80
`define GPI_OFS_EVT_MASK  8'h84
`define GPI_RST_WORD      32'h0000_0000
`define GPI_RST_INCON     32'h0000_0000
`define GPI_EVT_W         2
`define GPI_EVT_PEND_BIT  0
`define GPI_EVT_ADDR_BIT  1
`define GPI_RESP_OKAY     2'h0
`define GPI_RESP_SLVERR   2'h2
`endif

/* pkg/gpi_pkg.sv */
`include "gpi_defines.svh"

package gpi_pkg;

    typedef logic [`GPI_PINS-1:0] gpi_word_t;

    // ****************************************************************
    // Register and bus state of the flag block
    // ****************************************************************
    typedef struct packed {
        gpi_word_t              mode;
        gpi_word_t              pol;
        gpi_word_t              incon;
        gpi_word_t              dual;
        gpi_word_t              en;
        gpi_word_t              pend;
        logic [`GPI_EVT_W-1:0]  evt_stat;
        logic [`GPI_EVT_W-1:0]  evt_mask;
        logic                   wait_r;
        logic [31:0]            rdata;
        logic [1:0]             resp;
        logic                   port_irq;
        logic                   blk_irq;
    } gpi_state_t;

    // ****************************************************************
    // Pin sampling state of the detector
    // ****************************************************************
    typedef struct packed {
        gpi_word_t  sync1;
        gpi_word_t  sync2;
        gpi_word_t  prev;
    } gpi_det_state_t;

endpackage : gpi_pkg

/* pkg/gpi_det_if.sv */
// Trigger settings toward the detector and pin events back.
interface gpi_det_if;
    import gpi_pkg::*;
    gpi_word_t  mode;
    gpi_word_t  pol;
    gpi_word_t  dual;
    gpi_word_t  incon;
    gpi_word_t  pin_event;

    modport cfg (output mode, pol, dual, incon, input pin_event);
    modport det (input mode, pol, dual, incon, output pin_event);
endinterface : gpi_det_if

/* hw/gpi_pin_detect.sv */
module gpi_pin_detect
    import gpi_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Raw pin levels
    input  wire gpi_word_t  pin_raw,
    // Settings and events
    gpi_det_if.det          dif
);

    gpi_det_state_t r_reg;
    gpi_det_state_t r_next;
    gpi_word_t      rise;
    gpi_word_t      fall;
    gpi_word_t      lvl_hit;
    gpi_word_t      edg_hit;

    // Pins are asynchronous; sync1 feeds only sync2.
    always_comb begin
        r_next = r_reg;
        r_next.sync1 = pin_raw;
        r_next.sync2 = r_reg.sync1;
        r_next.prev  = r_reg.sync2;
    end

    // Edges come from the settled copy and its one-cycle history.
    assign rise    = r_reg.sync2 & ~r_reg.prev;
    assign fall    = ~r_reg.sync2 & r_reg.prev;
    assign lvl_hit = ~(r_reg.sync2 ^ dif.pol); // RULE11
    assign edg_hit = (dif.dual & (rise | fall)) // RULE12
                   | (~dif.dual & ((dif.pol & rise) | (~dif.pol & fall)));
    // Disconnected pins see nothing, whatever the trigger settings.
    assign dif.pin_event = dif.incon // RULE13
                         & ((dif.mode & edg_hit) | (~dif.mode & lvl_hit));

    // State register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);

    no_detect_off_a: assert property ((dif.pin_event & ~dif.incon) == '0) // RULE13
        else $error("Event on a disconnected pin.");
    level_match_a: assert property ( // RULE10
        (dif.pin_event & ~dif.mode & (r_reg.sync2 ^ dif.pol)) == '0)
        else $error("Level event with the wrong input level.");
    edge_need_a: assert property ( // RULE12
        (dif.pin_event & dif.mode & ~(r_reg.sync2 ^ r_reg.prev)) == '0)
        else $error("Edge event without a pin change.");

endmodule : gpi_pin_detect

/* hw/gpi_irq_flags.sv */
module gpi_irq_flags
    import gpi_pkg::*;
#(
    parameter int                  ADDR_W    = 8,
    parameter logic [`GPI_PINS-1:0] INCON_RST = `GPI_RST_INCON
) (
    // Clock and reset
    input  wire logic              CORE_CLK,
    input  wire logic              RESETN,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] AVS_ADDRESS,
    input  wire logic              AVS_READ,
    input  wire logic              AVS_WRITE,
    input  wire logic [31:0]       AVS_WRITEDATA,
    input  wire logic [3:0]        AVS_BYTEENABLE,
    output logic      [31:0]       AVS_READDATA,
    output logic      [1:0]        AVS_RESPONSE,
    output logic                   AVS_WAITREQUEST,
    // Port pins
    input  wire logic [`GPI_PINS-1:0] PIN_IN,
    // Interrupt outputs
    output logic                   PORT_IRQ,
    output logic                   BLK_IRQ
);

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Expands byte enables into a bit mask.
    function automatic gpi_word_t be_mask(input logic [3:0] be);
        gpi_word_t m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction : be_mask

    // Lays the enabled bytes of new data over the old word.
    function automatic gpi_word_t merge(input gpi_word_t old_w,
                                       input gpi_word_t new_w,
                                       input logic [3:0] be);
        return (old_w & ~be_mask(be)) | (new_w & be_mask(be));
    endfunction : merge

    // Tells whether an offset belongs to the block.
    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            `GPI_OFS_MODE, `GPI_OFS_POL, `GPI_OFS_INCON, `GPI_OFS_EN,
            `GPI_OFS_EN_SET, `GPI_OFS_EN_CLR, `GPI_OFS_PEND,
            `GPI_OFS_FL_CLR, `GPI_OFS_WKEN, `GPI_OFS_WKEN_SET,
            `GPI_OFS_WKEN_CLR, `GPI_OFS_DUAL, `GPI_OFS_EVT_STAT,
            `GPI_OFS_EVT_MASK: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : is_mapped

    // ****************************************************************
    // State and wiring
    // ****************************************************************

    localparam gpi_state_t ST_RST = '{
        mode:     `GPI_RST_WORD,
        pol:      `GPI_RST_WORD,
        incon:    INCON_RST,
        dual:     `GPI_RST_WORD,
        en:       `GPI_RST_WORD,
        pend:     `GPI_RST_WORD,
        evt_stat: '0,
        evt_mask: '0,
        wait_r:   1'b1,
        rdata:    32'h0000_0000,
        resp:     `GPI_RESP_OKAY,
        port_irq: 1'b0,
        blk_irq:  1'b0
    };

    gpi_state_t  r_reg;
    gpi_state_t  r_next;
    gpi_det_if   dif ();
    logic [7:0]  addr;
    logic        req;
    logic        rd_commit;
    logic        wr_commit;
    gpi_word_t   wdm;
    gpi_word_t   rd_word;

    assign addr = 8'(AVS_ADDRESS);
    assign req  = AVS_READ | AVS_WRITE;
    // A request completes at the edge where waitrequest is seen low.
    assign rd_commit = AVS_READ & ~r_reg.wait_r;
    assign wr_commit = AVS_WRITE & ~r_reg.wait_r;
    assign wdm = AVS_WRITEDATA & be_mask(AVS_BYTEENABLE);

    // Trigger settings go out from flops so the detector sees steady values.
    assign dif.mode  = r_reg.mode;
    assign dif.pol   = r_reg.pol;
    assign dif.dual  = r_reg.dual;
    assign dif.incon = r_reg.incon;

    // ****************************************************************
    // Pin event detection
    // ****************************************************************

    gpi_pin_detect u_detect (
        .clk     (CORE_CLK),
        .rst_n   (RESETN),
        .pin_raw (PIN_IN),
        .dif     (dif.det)
    );

    // ****************************************************************
    // Read multiplexer
    // ****************************************************************

    // Alias, clear and wakeup slots read as zero.
    always_comb begin
        case (addr)
            `GPI_OFS_MODE:     rd_word = r_reg.mode;
            `GPI_OFS_POL:      rd_word = r_reg.pol;
            `GPI_OFS_INCON:    rd_word = r_reg.incon;
            `GPI_OFS_EN:       rd_word = r_reg.en;
            `GPI_OFS_PEND:     rd_word = r_reg.pend; // RULE5
            `GPI_OFS_WKEN:     rd_word = '0; // RULE9
            `GPI_OFS_DUAL:     rd_word = r_reg.dual;
            `GPI_OFS_EVT_STAT: rd_word = 32'(r_reg.evt_stat);
            `GPI_OFS_EVT_MASK: rd_word = 32'(r_reg.evt_mask);
            default:           rd_word = '0;
        endcase
    end

    // ****************************************************************
    // Next-state logic
    // ****************************************************************

    // One wait cycle per access keeps read data registered, at the cost
    // of a two-cycle access.
    always_comb begin
        gpi_word_t clr;
        clr = '0;
        r_next = r_reg;
        r_next.wait_r = ~(req & r_reg.wait_r);
        if (req & r_reg.wait_r) begin
            r_next.rdata = AVS_READ ? rd_word : 32'h0000_0000;
            r_next.resp  = is_mapped(addr) ? `GPI_RESP_OKAY
                                           : `GPI_RESP_SLVERR;
        end
        if (wr_commit) begin
            case (addr)
                `GPI_OFS_MODE:
                    r_next.mode = merge(r_reg.mode, AVS_WRITEDATA,
                                        AVS_BYTEENABLE); // RULE10
                `GPI_OFS_POL:
                    r_next.pol = merge(r_reg.pol, AVS_WRITEDATA,
                                       AVS_BYTEENABLE); // RULE11
                `GPI_OFS_INCON:
                    r_next.incon = merge(r_reg.incon, AVS_WRITEDATA,
                                         AVS_BYTEENABLE); // RULE13
                `GPI_OFS_EN:
                    r_next.en = merge(r_reg.en, AVS_WRITEDATA,
                                      AVS_BYTEENABLE); // RULE1
                `GPI_OFS_EN_SET:
                    r_next.en = r_reg.en | wdm; // RULE3
                `GPI_OFS_EN_CLR:
                    r_next.en = r_reg.en & ~wdm; // RULE4
                `GPI_OFS_FL_CLR:
                    clr = wdm; // RULE6 RULE7
                `GPI_OFS_DUAL:
                    r_next.dual = merge(r_reg.dual, AVS_WRITEDATA,
                                        AVS_BYTEENABLE); // RULE12
                `GPI_OFS_EVT_MASK:
                    r_next.evt_mask = `GPI_EVT_W'(merge(
                        32'(r_reg.evt_mask), AVS_WRITEDATA,
                        AVS_BYTEENABLE));
                default: ;
            endcase
        end
        // A pin event in the cycle of its clear wins over the clear.
        r_next.pend = (r_reg.pend & ~clr) | dif.pin_event; // RULE2 RULE6
        // Reading the event status clears it; a new event still lands.
        if (rd_commit && addr == `GPI_OFS_EVT_STAT) begin
            r_next.evt_stat = '0;
        end
        if (|(dif.pin_event & ~r_reg.pend)) begin
            r_next.evt_stat[`GPI_EVT_PEND_BIT] = 1'b1;
        end
        if ((rd_commit | wr_commit) && !is_mapped(addr)) begin
            r_next.evt_stat[`GPI_EVT_ADDR_BIT] = 1'b1;
        end
        r_next.port_irq = |(r_next.pend & r_next.en); // RULE14 RULE1
        r_next.blk_irq  = |(r_next.evt_stat & r_next.evt_mask);
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            r_reg <= ST_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // Every output is a flop of the state.
    assign AVS_READDATA    = r_reg.rdata;
    assign AVS_RESPONSE    = r_reg.resp;
    assign AVS_WAITREQUEST = r_reg.wait_r;
    assign PORT_IRQ        = r_reg.port_irq;
    assign BLK_IRQ         = r_reg.blk_irq;

    // ****************************************************************
    // Assertions
    // ****************************************************************

    default clocking cc @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);

    mask_write_a: assert property ( // RULE1
        wr_commit && addr == `GPI_OFS_EN && AVS_BYTEENABLE == 4'hf
        |=> r_reg.en == $past(AVS_WRITEDATA))
        else $error("Enable mask did not take the written word.");

    en_off_keeps_a: assert property ( // RULE2
        !(wr_commit && addr == `GPI_OFS_FL_CLR)
        |=> ($past(r_reg.pend) & ~r_reg.pend) == '0)
        else $error("Pending flag lost without a flag clear.");

    set_alias_a: assert property ( // RULE3
        wr_commit && addr == `GPI_OFS_EN_SET && AVS_BYTEENABLE == 4'hf
        |=> r_reg.en == ($past(r_reg.en) | $past(AVS_WRITEDATA)))
        else $error("Enable set alias gave a wrong mask.");

    clr_alias_a: assert property ( // RULE4
        wr_commit && addr == `GPI_OFS_EN_CLR && AVS_BYTEENABLE == 4'hf
        |=> r_reg.en == ($past(r_reg.en) & ~$past(AVS_WRITEDATA)))
        else $error("Enable clear alias gave a wrong mask.");

    pend_read_a: assert property ( // RULE5
        rd_commit && addr == `GPI_OFS_PEND
        |-> AVS_READDATA == $past(r_reg.pend) && !AVS_WAITREQUEST)
        else $error("Pending read returned the wrong word.");

    flag_clear_a: assert property ( // RULE6
        wr_commit && addr == `GPI_OFS_FL_CLR && AVS_BYTEENABLE == 4'hf
        |=> (r_reg.pend & $past(AVS_WRITEDATA)
             & ~$past(dif.pin_event)) == '0)
        else $error("Flag clear left a written flag set.");

    zero_keeps_a: assert property ( // RULE7
        wr_commit && addr == `GPI_OFS_FL_CLR
        |=> ($past(r_reg.pend) & ~$past(wdm) & ~r_reg.pend) == '0)
        else $error("Writing zero cleared a pending flag.");

    wken_zero_a: assert property ( // RULE9
        rd_commit && addr == `GPI_OFS_WKEN |-> AVS_READDATA == '0)
        else $error("Wakeup slot did not read zero.");

    port_irq_a: assert property ( // RULE14
        PORT_IRQ == |(r_reg.pend & r_reg.en))
        else $error("Port interrupt disagrees with pending and enable.");

    one_wait_a: assert property (
        req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("Access was not answered after one wait cycle.");

    cov_flag_clear_c: cover property (
        wr_commit && addr == `GPI_OFS_FL_CLR ##1 PORT_IRQ == 1'b0);
    cov_irq_rise_c: cover property (!PORT_IRQ ##1 PORT_IRQ);
    cov_bad_addr_c: cover property (
        (rd_commit | wr_commit) && !is_mapped(addr) ##1 !BLK_IRQ);
    cov_event_c: cover property (|dif.pin_event);

endmodule : gpi_irq_flags

/* testbench/gpio_pin_interrupt_flags_bench.sv */
`include "gpi_defines.svh"

module gpio_pin_interrupt_flags_bench
    import gpi_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Signals, models and counters
    // ****************************************************************
    localparam logic [7:0] ADR_HOLE = 8'h90;
    logic        clk;
    logic        rst_n;
    logic [7:0]  addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [31:0] rdata;
    logic [1:0]  resp;
    logic        waitreq;
    gpi_word_t   pins;
    logic        port_irq;
    logic        blk_irq;
    int          error_cnt;
    int          tests_run;
    logic [31:0] seed;
    logic [31:0] rv;
    logic [1:0]  rs;
    gpi_word_t   v;
    gpi_word_t   lvl;
    gpi_word_t   en_m;
    gpi_word_t   pend_m;
    gpi_word_t   pol_m;
    gpi_word_t   dual_m;
    gpi_word_t   incon_m;

    gpi_irq_flags DUT (
        .CORE_CLK        (clk),
        .RESETN          (rst_n),
        .AVS_ADDRESS     (addr),
        .AVS_READ        (rd),
        .AVS_WRITE       (wr),
        .AVS_WRITEDATA   (wdata),
        .AVS_BYTEENABLE  (be),
        .AVS_READDATA    (rdata),
        .AVS_RESPONSE    (resp),
        .AVS_WAITREQUEST (waitreq),
        .PIN_IN          (pins),
        .PORT_IRQ        (port_irq),
        .BLK_IRQ         (blk_irq)
    );

    // Free-running 50 MHz clock.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Xorshift keeps the random stream repeatable from one run to next.
    function automatic gpi_word_t rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Flags that one pin change should raise in edge mode.
    function automatic gpi_word_t edge_exp(gpi_word_t chg, logic rise);
        gpi_word_t act;
        act = rise ? (pol_m | dual_m) : (~pol_m | dual_m);
        return chg & incon_m & act;
    endfunction : edge_exp

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One bus access; the request is held until waitrequest samples low.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] b);
        int n;
        n = 0;
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        be    <= b;
        rd    <= !w;
        wr    <= w;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            $display("ERROR at %0t: bus access never answered", $time);
        end
        rv = rdata;
        rs = resp;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask : wr32

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hf);
        check(rv, exp);
    endtask : rd_chk

    // Pin changes are launched on an edge and given time to settle.
    task automatic drive_pins(input gpi_word_t p);
        @(posedge clk);
        pins <= p;
        repeat (6) @(posedge clk);
    endtask : drive_pins

    task automatic test_done();
        $display("checks run %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    // Watchdog sized well above the few hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        $display("ERROR at %0t: watchdog expired", $time);
        test_done();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        rst_n = 1'b0; rd = 1'b0; wr = 1'b0; addr = 8'h0; wdata = 32'h0;
        be = 4'hf; pins = '0; error_cnt = 0; tests_run = 0;
        seed = 32'd18; en_m = '0; pend_m = '0; pol_m = '0; dual_m = '0;
        incon_m = '0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(`GPI_OFS_EN, 32'h0);
        rd_chk(`GPI_OFS_PEND, 32'h0);
        rd_chk(`GPI_OFS_WKEN, 32'h0);
        check(port_irq, 1'b0);
        $display("reset values done");
        // Direct writes, then both aliases, with zero words as corners.
        for (int i = 0; i < 4; i++) begin
            v = rnd(); wr32(`GPI_OFS_EN, v); en_m = v;
            rd_chk(`GPI_OFS_EN, en_m);
            v = (i == 0) ? '0 : rnd(); wr32(`GPI_OFS_EN_SET, v);
            en_m = en_m | v;
            rd_chk(`GPI_OFS_EN, en_m);
            v = (i == 0) ? '0 : rnd(); wr32(`GPI_OFS_EN_CLR, v);
            en_m = en_m & ~v;
            rd_chk(`GPI_OFS_EN, en_m);
        end
        bus(1'b1, `GPI_OFS_EN, 32'hffff_ffff, 4'h2);
        en_m[15:8] = 8'hff;
        rd_chk(`GPI_OFS_EN, en_m);
        $display("enable mask done");
        // Edge mode with random polarity, dual edge and input connect.
        wr32(`GPI_OFS_MODE, 32'hffff_ffff);
        for (int i = 0; i < 5; i++) begin
            pol_m = rnd(); dual_m = rnd();
            incon_m = (i == 0) ? '1 : rnd();
            wr32(`GPI_OFS_POL, pol_m);
            wr32(`GPI_OFS_DUAL, dual_m);
            wr32(`GPI_OFS_INCON, incon_m);
            v = rnd();
            drive_pins(v);
            pend_m = pend_m | edge_exp(v, 1'b1);
            rd_chk(`GPI_OFS_PEND, pend_m);
            drive_pins('0);
            pend_m = pend_m | edge_exp(v, 1'b0);
            rd_chk(`GPI_OFS_PEND, pend_m);
            check(port_irq, |(pend_m & en_m));
            v = (i == 1) ? '0 : rnd(); wr32(`GPI_OFS_FL_CLR, v);
            pend_m = pend_m & ~v;
            rd_chk(`GPI_OFS_PEND, pend_m);
        end
        $display("edge detection done");
        // Disabling must not touch flags; read-only and reserved slots.
        incon_m = '1;
        wr32(`GPI_OFS_INCON, incon_m);
        drive_pins('1);
        pend_m = pend_m | edge_exp('1, 1'b1);
        wr32(`GPI_OFS_EN, pend_m); en_m = pend_m;
        repeat (2) @(posedge clk);
        check(port_irq, |pend_m);
        wr32(`GPI_OFS_EN_CLR, 32'hffff_ffff); en_m = '0;
        rd_chk(`GPI_OFS_PEND, pend_m);
        check(port_irq, 1'b0);
        wr32(`GPI_OFS_PEND, 32'h0);
        rd_chk(`GPI_OFS_PEND, pend_m);
        // Software leaves the reserved slot at its reset value.
        wr32(`GPI_OFS_WKEN, 32'h0);
        rd_chk(`GPI_OFS_WKEN, 32'h0);
        wr32(`GPI_OFS_FL_CLR, 32'hffff_ffff); pend_m = '0;
        rd_chk(`GPI_OFS_PEND, pend_m);
        $display("enable versus pending done");
        // Level mode re-raises a flag for as long as the level matches.
        pol_m = rnd(); wr32(`GPI_OFS_POL, pol_m);
        v = rnd();
        drive_pins(v);
        pend_m = edge_exp(~v, 1'b0);
        wr32(`GPI_OFS_MODE, 32'h0);
        repeat (3) @(posedge clk);
        lvl = ~(v ^ pol_m) & incon_m;
        rd_chk(`GPI_OFS_PEND, pend_m | lvl);
        wr32(`GPI_OFS_FL_CLR, 32'hffff_ffff);
        rd_chk(`GPI_OFS_PEND, lvl);
        wr32(`GPI_OFS_MODE, 32'hffff_ffff);
        wr32(`GPI_OFS_FL_CLR, 32'hffff_ffff);
        rd_chk(`GPI_OFS_PEND, 32'h0);
        $display("level detection done");
        // Block interrupt: raise on an unmapped access, mask, clear.
        bus(1'b0, `GPI_OFS_EVT_STAT, 32'h0, 4'hf);
        // Earlier pin flags have raised only the pin event bit.
        check(rv, 32'h1);
        check(rs, `GPI_RESP_OKAY);
        wr32(`GPI_OFS_EVT_MASK, 32'h2);
        bus(1'b0, ADR_HOLE, 32'h0, 4'hf);
        check(rs, `GPI_RESP_SLVERR);
        check(rv, 32'h0);
        repeat (2) @(posedge clk);
        check(blk_irq, 1'b1);
        wr32(`GPI_OFS_EVT_MASK, 32'h0);
        repeat (2) @(posedge clk);
        check(blk_irq, 1'b0);
        wr32(`GPI_OFS_EVT_MASK, 32'h2);
        repeat (2) @(posedge clk);
        check(blk_irq, 1'b1);
        rd_chk(`GPI_OFS_EVT_STAT, 32'h2);
        repeat (2) @(posedge clk);
        check(blk_irq, 1'b0);
        $display("block interrupt done");
        test_done();
    end

endmodule : gpio_pin_interrupt_flags_bench
